// >>> rtl/ast_transmitter.sv
// Purpose: Async serial transmitter with Avalon-MM register access
// Assumes: baud_tick is a one-cycle pulse per bit period
// Notes: Generator, receiver and sync mode live elsewhere
// Functional notes
// - Transmit only with enable set, clocked mode clear, port on.
// - Port enable forces the transmit pin to drive.
// - Port enable forces receive pin input; level readable, latch off.
// - Enabling the transmitter sets the empty flag.
// - Holding write starts sending; idle shifter takes it at once.
// - Queued character enters shifter within one cycle after stop.
// - Loaded character is sent immediately: start, data, stop.
// - Invert bit flips idle level and data on the line.
// - Empty flag set while transmitter enabled and no character queued.
// - Empty flag valid from the second cycle after a write.
// - Empty flag is read-only.
// - Interrupt needs its enable; flag ignores the enable.
// - Shifter-empty flag read-only, clear from load to last bit.
// - Nine-bit mode sends nine data bits.
// - Ninth bit is the MSb, loaded with the low byte.
// - Enabling interrupt with flag set fires if both gates set.
// - Shifter is hidden; it loads only from the holding register.
// - Frame: start at space, data, stop at mark; idle at mark.
// - Data goes out LSb first.
module ast_transmitter
  import ast_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Baud generator
  input wire logic baud_tick,
  output logic [15:0] baud_divisor,
  output logic high_speed_baud,
  output logic wide_baud_divisor,
  // General port fallback
  input wire logic port_latch_tx,
  input wire logic port_latch_rx,
  input wire logic pin_dir_tx,
  input wire logic pin_dir_rx,
  output logic [1:0] port_levels,
  // Pins
  input wire logic transmit_pin_i,
  output logic transmit_pin_o,
  output logic transmit_pin_oe,
  input wire logic receive_pin_i,
  output logic receive_pin_o,
  output logic receive_pin_oe,
  // Interrupt
  output logic irq
);
  logic rst_meta_reg, rst_int_n;
  logic wait_reg, wait_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [7:0] intctl_reg, pen_reg, ppri_reg, rxsc_reg, txsc_reg;
  logic [7:0] baud_reg, divh_reg, divl_reg, hold_reg;
  logic hold_full_reg, hold_full_next;
  logic txef_reg, txef_next;
  logic irq_reg, irq_next;
  logic txo_reg, txo_next, txoe_reg, txoe_next;
  logic rxo_reg, rxoe_reg, rxoe_next;
  logic [1:0] lvl_reg;
  logic wr_ok, rd_take, wr_hold;
  logic serial_port_enable, transmit_enable_bit, sync_sel, nine, inv, transmit_irq_enable, global_irq_enable, peripheral_irq_enable;
  logic tx_active, line_level;
  logic [7:0] rd_mux, pflag_view, txsc_view;
  ast_shift_if sif ();

  function automatic logic [7:0] mwr(logic [7:0] old, logic [7:0] nw,
                                     logic [7:0] mask);
    mwr = (old & ~mask) | (nw & mask);
  endfunction

  function automatic logic hit(logic [ADDR_W-1:0] ofs);
    hit = wr_ok && avs_address == ofs;
  endfunction

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_int_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_int_n <= rst_meta_reg;
    end
  end

  // Bus: one wait cycle, then the access completes
  assign rd_take = avs_read & wait_reg;
  assign wr_ok = avs_write & ~wait_reg & avs_byteenable[0];
  assign wait_next = ~((avs_read | avs_write) & wait_reg);
  // Spelled out: a function reading module nets would not re-trigger here
  assign wr_hold = wr_ok && avs_address == OFS_HOLD;

  assign serial_port_enable = rxsc_reg[B_SERIAL_PORT_ENABLE];
  assign transmit_enable_bit = txsc_reg[B_TRANSMIT_ENABLE_BIT];
  assign sync_sel = txsc_reg[B_SYNC];
  assign nine = txsc_reg[B_NINE];
  assign inv = baud_reg[B_INV];
  assign transmit_irq_enable = pen_reg[B_TRANSMIT_IRQ_ENABLE];
  assign global_irq_enable = intctl_reg[B_GIE];
  assign peripheral_irq_enable = intctl_reg[B_PERIPHERAL_IRQ_ENABLE];
  assign tx_active = transmit_enable_bit & ~sync_sel & serial_port_enable;

  // Flags are views of state; writes never reach them
  assign pflag_view = 8'(txef_reg) << B_TXEF;
  assign txsc_view = (txsc_reg & ~8'(1 << B_SHIFTER_EMPTY_FLAG)) |
    ({7'h00, ~sif.busy} << B_SHIFTER_EMPTY_FLAG);

  assign rd_mux =
    avs_address == OFS_INTCTL ? intctl_reg :
    avs_address == OFS_PFLAG ? pflag_view :
    avs_address == OFS_PEN ? pen_reg :
    avs_address == OFS_PPRI ? ppri_reg :
    avs_address == OFS_RXSC ? rxsc_reg :
    avs_address == OFS_TXSC ? txsc_view :
    avs_address == OFS_BAUD ? baud_reg :
    avs_address == OFS_DIVH ? divh_reg :
    avs_address == OFS_DIVL ? divl_reg : REG_RST;
  assign rdata_next = rd_take ? {24'h000000, rd_mux} : rdata_reg;

  // Hand-off into the shifter; write sets win over transfer clears
  assign sif.load = tx_active & hold_full_reg & ~sif.busy;
  assign sif.data = {txsc_reg[B_TRANSMIT_NINTH_BIT], hold_reg};
  assign sif.nine = nine;
  assign sif.tick = baud_tick;
  assign sif.abort = ~tx_active;
  assign hold_full_next = wr_hold |
    (hold_full_reg & ~sif.load & tx_active);
  assign txef_next = transmit_enable_bit & ~hold_full_reg;
  assign irq_next = global_irq_enable & peripheral_irq_enable & transmit_irq_enable & txef_reg;

  // Pins
  assign line_level = sif.busy ? sif.line : 1'b1;
  assign txo_next = serial_port_enable ? (tx_active ? line_level ^ inv : ~inv) :
    port_latch_tx;
  assign txoe_next = serial_port_enable | ~pin_dir_tx;
  assign rxoe_next = ~serial_port_enable & ~pin_dir_rx;

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      intctl_reg <= REG_RST;
      pen_reg <= REG_RST;
      ppri_reg <= REG_RST;
      rxsc_reg <= REG_RST;
      txsc_reg <= REG_RST;
      baud_reg <= REG_RST;
    end else begin
      if (hit(OFS_INTCTL)) intctl_reg <= avs_writedata[7:0];
      if (hit(OFS_PEN)) pen_reg <= avs_writedata[7:0];
      if (hit(OFS_PPRI)) ppri_reg <= avs_writedata[7:0];
      if (hit(OFS_RXSC))
        rxsc_reg <= mwr(rxsc_reg, avs_writedata[7:0], RXSC_MASK);
      if (hit(OFS_TXSC))
        txsc_reg <= mwr(txsc_reg, avs_writedata[7:0], TXSC_MASK);
      if (hit(OFS_BAUD))
        baud_reg <= mwr(baud_reg, avs_writedata[7:0], BAUD_MASK);
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      divh_reg <= REG_RST;
      divl_reg <= REG_RST;
      hold_reg <= REG_RST;
      hold_full_reg <= 1'b0;
      txef_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (hit(OFS_DIVH)) divh_reg <= avs_writedata[7:0];
      if (hit(OFS_DIVL)) divl_reg <= avs_writedata[7:0];
      if (wr_hold) hold_reg <= avs_writedata[7:0];
      hold_full_reg <= hold_full_next;
      txef_reg <= txef_next;
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      txo_reg <= 1'b1;
      txoe_reg <= 1'b0;
      rxo_reg <= 1'b0;
      rxoe_reg <= 1'b0;
      lvl_reg <= 2'h0;
    end else begin
      txo_reg <= txo_next;
      txoe_reg <= txoe_next;
      rxo_reg <= port_latch_rx;
      rxoe_reg <= rxoe_next;
      lvl_reg <= {receive_pin_i, transmit_pin_i};
    end
  end

  ast_shifter u_shifter (
    .clk(clk),
    .rst_int_n(rst_int_n),
    .sif(sif)
  );

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign baud_divisor = {divh_reg, divl_reg};
  assign high_speed_baud = txsc_reg[B_HSPD];
  assign wide_baud_divisor = baud_reg[B_WIDE];
  assign port_levels = lvl_reg;
  assign transmit_pin_o = txo_reg;
  assign transmit_pin_oe = txoe_reg;
  assign receive_pin_o = rxo_reg;
  assign receive_pin_oe = rxoe_reg;
  assign irq = irq_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_int_n);

  chk_load_gated: assert property (
    sif.load |-> transmit_enable_bit && !sync_sel && serial_port_enable)
    else $error("shifter loaded while port inactive");
  chk_tx_drives: assert property (
    serial_port_enable |=> transmit_pin_oe)
    else $error("transmit pin not driven with port on");
  chk_rx_input: assert property (
    serial_port_enable |=> !receive_pin_oe)
    else $error("receive pin driven with port on");
  chk_enable_flag: assert property (
    $rose(transmit_enable_bit) && !hold_full_reg |=> txef_reg)
    else $error("empty flag not set on enable");
  chk_direct_load: assert property (
    wr_hold && !sif.busy && tx_active ##1 tx_active |-> sif.load)
    else $error("idle shifter did not take the write");
  chk_handoff: assert property (
    $fell(sif.busy) && tx_active && hold_full_reg |-> sif.load)
    else $error("queued character not handed off");
  chk_idle_level: assert property (
    serial_port_enable && !sif.busy ##1 serial_port_enable |-> transmit_pin_o == ~$past(inv))
    else $error("idle level wrong for polarity");
  chk_flag_settle: assert property (
    wr_hold && transmit_enable_bit ##1 hold_full_reg && transmit_enable_bit |=> !txef_reg)
    else $error("empty flag not clear two cycles after write");
  chk_irq_gate: assert property (
    !transmit_irq_enable |=> !irq)
    else $error("interrupt without its enable");
  chk_irq_prompt: assert property (
    $rose(transmit_irq_enable) && txef_reg && global_irq_enable && peripheral_irq_enable |=> irq)
    else $error("interrupt late after enable");
  chk_shift_empty: assert property (
    sif.load |=> txsc_view[B_SHIFTER_EMPTY_FLAG] == 1'b0)
    else $error("shifter-empty flag not cleared on load");

  cov_first_char: cover property (wr_hold ##1 sif.load);
  cov_back_to_back: cover property (
    $fell(sif.busy) && hold_full_reg ##0 sif.load);
  cov_irq: cover property ($rose(irq));
  cov_inverted: cover property (sif.busy && inv);
endmodule

// >>> rtl/ast_pkg.sv
// Purpose: Shared constants for the async serial transmitter
// Assumes: 10 MHz clock, byte addresses on the register bus
// Notes: Unmapped addresses and the holding register read as zero
package ast_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam logic [5:0] OFS_INTCTL = 6'h00;
  localparam logic [5:0] OFS_PFLAG = 6'h04;
  localparam logic [5:0] OFS_PEN = 6'h08;
  localparam logic [5:0] OFS_PPRI = 6'h0C;
  localparam logic [5:0] OFS_RXSC = 6'h10;
  localparam logic [5:0] OFS_HOLD = 6'h14;
  localparam logic [5:0] OFS_TXSC = 6'h18;
  localparam logic [5:0] OFS_BAUD = 6'h1C;
  localparam logic [5:0] OFS_DIVH = 6'h20;
  localparam logic [5:0] OFS_DIVL = 6'h24;
  // Bit positions
  localparam int B_GIE = 7;
  localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int B_TXEF = 4;
  localparam int B_TRANSMIT_IRQ_ENABLE = 4;
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_NINE = 6;
  localparam int B_TRANSMIT_ENABLE_BIT = 5;
  localparam int B_SYNC = 4;
  localparam int B_HSPD = 2;
  localparam int B_SHIFTER_EMPTY_FLAG = 1;
  localparam int B_TRANSMIT_NINTH_BIT = 0;
  localparam int B_INV = 4;
  localparam int B_WIDE = 3;
  // Writable bits per register
  localparam logic [7:0] RXSC_MASK = 8'hF8;
  localparam logic [7:0] TXSC_MASK = 8'hFD;
  localparam logic [7:0] BAUD_MASK = 8'h3B;
  localparam logic [7:0] REG_RST = 8'h00;
  // Frame lengths including start and stop bit
  localparam logic [3:0] FRAME8 = 4'hA;
  localparam logic [3:0] FRAME9 = 4'hB;
  localparam logic [3:0] LAST_BIT = 4'h1;
  localparam logic [10:0] FRAME_IDLE = 11'h7FF;
  // Timing
  localparam int CLK_NS = 100;
  localparam int TCY_NS = 100;
  localparam int HANDOFF_CYC = TCY_NS / CLK_NS;
  localparam int FLAG_SETTLE_CYC = 2;
endpackage

// >>> rtl/ast_shift_if.sv
// Purpose: Link between register side and the bit shifter
// Assumes: One clock domain
// Notes: Line is the true-polarity serial level
interface ast_shift_if;
  logic load;
  logic [8:0] data;
  logic nine;
  logic tick;
  logic abort;
  logic busy;
  logic line;
  modport ctrl(output load, data, nine, tick, abort,
    input busy, line);
  modport shifter(input load, data, nine, tick, abort,
    output busy, line);
endinterface

// >>> rtl/ast_shifter.sv
// Purpose: Serialises one frame: start, 8 or 9 data bits, stop
// Assumes: Tick is a one-cycle pulse from the baud generator
// Notes: Line idles at mark; the start bit appears right after load
module ast_shifter
  import ast_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_int_n,
  // Control
  ast_shift_if.shifter sif
);
  logic [10:0] frame_reg, frame_next;
  logic [3:0] left_reg, left_next;
  logic busy_reg, busy_next;
  logic step;

  function automatic logic [10:0] frame_of(logic [8:0] d, logic nine);
    frame_of = nine ? {1'b1, d, 1'b0} : {2'h3, d[7:0], 1'b0};
  endfunction

  assign step = busy_reg & sif.tick;
  // LSb leaves first; ones fill in behind as stop bit and idle
  assign frame_next = sif.abort ? FRAME_IDLE :
    sif.load ? frame_of(sif.data, sif.nine) :
    step ? {1'b1, frame_reg[10:1]} : frame_reg;
  assign left_next = sif.load ? (sif.nine ? FRAME9 : FRAME8) :
    step ? left_reg - 4'h1 : left_reg;
  assign busy_next = ~sif.abort & (sif.load |
    (busy_reg & ~(step & left_reg == LAST_BIT)));
  assign sif.busy = busy_reg;
  assign sif.line = frame_reg[0];

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      frame_reg <= FRAME_IDLE;
      left_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      left_reg <= left_next;
      busy_reg <= busy_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_int_n);

  chk_start_bit_low: assert property (
    sif.load && !sif.abort |=> busy_reg && !sif.line)
    else $error("start bit not driven after load");
  chk_frame_len: assert property (
    sif.load && !sif.abort |=>
      left_reg == ($past(sif.nine) ? FRAME9 : FRAME8))
    else $error("wrong frame length loaded");
  chk_lsb_first: assert property (
    step && left_reg > LAST_BIT && !sif.load && !sif.abort
      |=> sif.line == $past(frame_reg[1]))
    else $error("bit order broken");
  chk_stop_mark: assert property (
    busy_reg && left_reg == LAST_BIT |-> sif.line)
    else $error("stop bit not at mark");
  cov_nine_frame: cover property (sif.load && sif.nine);
endmodule

// >>> sim/ast_rx_model.sv
// Purpose: Remote async receiver model watching the transmit line
// Assumes: Each bit is sampled one clock after the tick that ends it,
//   while it still stands on the registered pin
// Notes: Starts a frame only while en is high, so config glitches pass
module ast_rx_model
  import ast_pkg::*;
(
  // Clock
  input wire logic clk,
  // Line and format
  input wire logic line,
  input wire logic tick,
  input wire logic inv,
  input wire logic nine,
  input wire logic en,
  // Result
  output logic [8:0] rx_data,
  output logic rx_stop,
  output int rx_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] bits_reg = '0;
  logic [3:0] idx_reg = '0;
  logic busy_reg = 1'b0;
  logic tick_d = 1'b0;
  wire logic lvl = line ^ inv;
  wire logic go = busy_reg || (en && !lvl);
  wire logic [3:0] last = nine ? 4'hA : 4'h9;
  initial begin
    rx_data = '0;
    rx_stop = 1'b0;
    rx_cnt = 0;
  end
  always @(posedge clk) begin
    tick_d <= tick;
    busy_reg <= go;
    if (go && tick_d) begin
      bits_reg[idx_reg] <= lvl;
      idx_reg <= idx_reg + 4'h1;
      if (idx_reg == last) begin
        rx_stop <= lvl;
        rx_data <= nine ? bits_reg[9:1] : {1'b0, bits_reg[8:1]};
        rx_cnt <= rx_cnt + 1;
        busy_reg <= 1'b0;
        idx_reg <= '0;
      end
    end
  end
endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench for the async serial transmitter
// Assumes: Baud tick every 8 clocks, made here
// Notes: Register rows and frame rows run from tables
module tb
  import ast_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdata;
  logic wait_q;
  logic tick = 1'b0;
  logic [2:0] div = '0;
  logic latch_tx = 1'b1;
  logic latch_rx = 1'b1;
  logic dir_tx = 1'b1;
  logic inv = 1'b0;
  logic nine = 1'b0;
  logic en = 1'b0;
  logic po, poe, ro, roe, irq, hs, wide;
  logic [1:0] lv;
  logic [15:0] bdiv;
  logic [8:0] rx_data;
  logic rx_stop;
  int rx_cnt;
  int failures = 0;
  int cmp_count = 0;
  int c;
  logic [7:0] q;
  wire logic pin = poe ? po : 1'b1;
  logic [21:0] regs [8] = '{
    {OFS_DIVH, 8'hAB, 8'hAB}, {OFS_DIVL, 8'hCD, 8'hCD},
    {OFS_BAUD, 8'hFF, 8'h3B}, {OFS_PPRI, 8'h5A, 8'h5A},
    {OFS_HOLD, 8'h77, 8'h00}, {OFS_PFLAG, 8'hFF, 8'h00},
    {6'h3C, 8'hFF, 8'h00}, {OFS_RXSC, 8'hFF, 8'hF8}};
  // Transmit control, baud control, expected nine-bit character
  logic [24:0] txr [3] = '{
    {8'h20, 8'h00, 9'h0A5}, {8'h61, 8'h00, 9'h13C},
    {8'h60, 8'h10, 9'h081}};

  always #50 clk = ~clk;
  always @(posedge clk) begin
    div <= div + 3'h1;
    tick <= (div == 3'h7);
  end

  ast_transmitter uut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(4'hF),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wait_q),
    .baud_tick(tick), .baud_divisor(bdiv), .high_speed_baud(hs),
    .wide_baud_divisor(wide), .port_latch_tx(latch_tx),
    .port_latch_rx(latch_rx), .pin_dir_tx(dir_tx), .pin_dir_rx(1'b0),
    .port_levels(lv), .transmit_pin_i(pin), .transmit_pin_o(po),
    .transmit_pin_oe(poe), .receive_pin_i(1'b1), .receive_pin_o(ro),
    .receive_pin_oe(roe), .irq(irq));

  ast_rx_model rx (.clk(clk), .line(po), .tick(tick), .inv(inv),
    .nine(nine), .en(en), .rx_data(rx_data), .rx_stop(rx_stop),
    .rx_cnt(rx_cnt));

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic [5:0] a,
    input logic [7:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_q !== 1'b0 && n < 20);
    if (n >= 20) begin
      failures++;
      conclude();
    end
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e});
  endtask

  task automatic cfg(input logic [7:0] t, input logic [7:0] b);
    en <= 1'b0;
    acc(1'b1, OFS_TXSC, t);
    acc(1'b1, OFS_BAUD, b);
    inv <= b[4];
    nine <= t[6];
    repeat (3) @(posedge clk);
    en <= 1'b1;
  endtask

  task automatic wait_rx(input int n_want);
    int n;
    n = 0;
    while (rx_cnt < n_want && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      conclude();
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    chk({wait_q, po, poe, irq}, 16'h000C);
    latch_tx <= 1'b0;
    dir_tx <= 1'b0;
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({po, poe, roe}, 16'h0003);
    dir_tx <= 1'b1;
    rchk(OFS_TXSC, 8'h02);
    rchk(OFS_PFLAG, 8'h00);
    foreach (regs[i]) begin
      acc(1'b1, regs[i][21:16], regs[i][15:8]);
      rchk(regs[i][21:16], regs[i][7:0]);
    end
    chk({poe, roe}, 16'h0002);
    chk(bdiv, 16'hABCD);
    chk({ro, lv, hs, wide}, 16'h0019);
    $display("register test done");
    acc(1'b1, OFS_RXSC, 8'h80);
    cfg(8'h20, 8'h00);
    rchk(OFS_PFLAG, 8'h10);
    acc(1'b1, OFS_INTCTL, 8'hC0);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    acc(1'b1, OFS_PEN, 8'h10);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    acc(1'b1, OFS_INTCTL, 8'h80);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    acc(1'b1, OFS_PEN, 8'h00);
    rchk(OFS_PFLAG, 8'h10);
    $display("interrupt test done");
    foreach (txr[i]) begin
      cfg(txr[i][24:17], txr[i][16:9]);
      chk(po, {15'h0000, ~txr[i][13]});
      c = rx_cnt;
      acc(1'b1, OFS_HOLD, txr[i][7:0]);
      wait_rx(c + 1);
      chk(rx_data, txr[i][8:0]);
      chk(rx_stop, 1'b1);
    end
    $display("frame test done");
    cfg(8'h20, 8'h00);
    c = rx_cnt;
    acc(1'b1, OFS_HOLD, 8'h11);
    acc(1'b1, OFS_HOLD, 8'h22);
    rchk(OFS_PFLAG, 8'h00);
    rchk(OFS_TXSC, 8'h20);
    wait_rx(c + 1);
    chk(rx_data, 9'h011);
    wait_rx(c + 2);
    chk(rx_data, 9'h022);
    rchk(OFS_PFLAG, 8'h10);
    rchk(OFS_TXSC, 8'h22);
    $display("back-to-back test done");
    acc(1'b1, OFS_HOLD, 8'hF0);
    repeat (20) @(posedge clk);
    acc(1'b1, OFS_TXSC, 8'h00);
    repeat (3) @(posedge clk);
    chk(po, 1'b1);
    rchk(OFS_TXSC, 8'h02);
    $display("abort test done");
    conclude();
  end
endmodule
